// ---- verilog/pcfp_top.sv ----
`timescale 1ns/1ns
module pcfp_top #(
   parameter int OCD_STEP_CYC = pcfp_pkg::OCD_STEP_MS * 1000 * pcfp_pkg::CLK_MHZ,
   parameter int OC_PERIOD_CYC = pcfp_pkg::OC_PERIOD_MS * 1000 * pcfp_pkg::CLK_MHZ
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   // register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // comparator results from the analog front end
   input  wire logic       ocd_cmp,
   input  wire logic       scd_cmp,
   input  wire logic       scc_cmp,
   input  wire logic       load_sense_pin,
   input  wire logic       charger_sense_pin,
   input  wire logic       cell_collapse,
   // trip level selects to the comparators
   output logic      [3:0] overcurrent_trip_sel,
   output logic      [3:0] dsg_short_trip_sel,
   output logic      [3:0] chg_short_trip_sel,
   // FET drives and power
   output logic            charge_fet_drive,
   output logic            discharge_fet_drive,
   output logic            ldo_off,
   output logic            load_cmp_en,
   // open-cell probe
   output logic            probe_en,
   output logic      [3:0] probe_cell
);
   // configuration registers
   logic [7:0] cfg_ocd;
   logic [7:0] cfg_scd;
   logic [7:0] cfg_scc;
   logic [7:0] cfg_misc;

   // fault latches and helpers
   logic       ocd_flt;
   logic       scd_flt;
   logic       scc_flt;
   logic       open_flt;
   logic       chg_seen;
   logic [11:0] load_cnt;
   logic [31:0] period_cnt;
   logic [4:0]  probe_cnt;
   logic [9:0]  miss;
   pcfp_pkg::pcfp_oc_state_t oc_state;
   pcfp_pkg::pcfp_oc_state_t next_oc_state;

   // register decode
   wire wr_ocd  = reg_wr & (reg_addr == pcfp_pkg::ADDR_OCD);
   wire wr_scd  = reg_wr & (reg_addr == pcfp_pkg::ADDR_SCD);
   wire wr_scc  = reg_wr & (reg_addr == pcfp_pkg::ADDR_SCC);
   wire wr_misc = reg_wr & (reg_addr == pcfp_pkg::ADDR_MISC);

   wire [3:0] ocd_dly = cfg_ocd[pcfp_pkg::DELAY_LSB +: pcfp_pkg::SEL_W];
   wire [3:0] scd_dly = cfg_scd[pcfp_pkg::DELAY_LSB +: pcfp_pkg::SEL_W];
   wire [3:0] scc_dly = cfg_scc[pcfp_pkg::DELAY_LSB +: pcfp_pkg::SEL_W];
   wire       recovery_mode_bit = cfg_misc[pcfp_pkg::MODE_BIT];
   wire [3:0] cells_raw = cfg_misc[pcfp_pkg::CELLS_LSB +: 4];

   // pack size clamped to the supported range
   wire [3:0] num_cells = (cells_raw < pcfp_pkg::MIN_CELLS) ? pcfp_pkg::MIN_CELLS :
                          (cells_raw > 4'(pcfp_pkg::MAX_CELLS)) ? 4'(pcfp_pkg::MAX_CELLS) :
                          cells_raw;

   // blanking lengths from delay selects
   wire [23:0] ocd_lim = 24'((32'(ocd_dly) + 32'd1) * 32'(OCD_STEP_CYC));
   wire [23:0] scd_lim = 24'((32'(scd_dly) + 32'(pcfp_pkg::SC_MIN_STEPS))
                             * 32'(pcfp_pkg::SC_STEP_CYC));
   wire [23:0] scc_lim = 24'((32'(scc_dly) + 32'(pcfp_pkg::SC_MIN_STEPS))
                             * 32'(pcfp_pkg::SC_STEP_CYC));

   wire ocd_hit;
   wire scd_hit;
   wire scc_hit;

   pcfp_qual u_ocd (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .cond     (ocd_cmp),
      .limit    (ocd_lim),
      .hit      (ocd_hit)
   );

   pcfp_qual u_scd (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .cond     (scd_cmp),
      .limit    (scd_lim),
      .hit      (scd_hit)
   );

   pcfp_qual u_scc (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .cond     (scc_cmp),
      .limit    (scc_lim),
      .hit      (scc_hit)
   );

   // charger and load sensing
   wire chg_present = charger_sense_pin;
   wire dsg_flt     = ocd_flt | scd_flt;
   wire load_win_done = (load_cnt == 12'(pcfp_pkg::LOAD_WIN_CYC));
   // load absent if it never rose within the window, or fell back below
   wire load_removed = load_cmp_en & load_win_done & ~load_sense_pin;
   wire dsg_release  = dsg_flt & load_removed &
                       (~recovery_mode_bit | chg_seen);
   wire scc_release  = scc_flt & ~chg_present;

   // open-cell sequencing
   wire period_tick = (period_cnt >= 32'(OC_PERIOD_CYC - 1));
   wire probe_done  = (probe_cnt == 5'(pcfp_pkg::PROBE_CYC - 1));
   wire oc_eval     = (oc_state == pcfp_pkg::PCFP_OC_EVAL);
   wire oc_miss     = oc_eval & cell_collapse;
   wire oc_set      = oc_miss & miss[probe_cell];
   wire last_cell   = (probe_cell >= (num_cells - 4'h1));

   wire any_flt     = ocd_flt | scd_flt | scc_flt | open_flt;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_ocd  <= pcfp_pkg::RST_OCD;
         cfg_scd  <= pcfp_pkg::RST_SCD;
         cfg_scc  <= pcfp_pkg::RST_SCC;
         cfg_misc <= pcfp_pkg::RST_MISC;
      end else begin
         if (wr_ocd) cfg_ocd <= reg_wdata;
         if (wr_scd) cfg_scd <= reg_wdata;
         if (wr_scc) cfg_scc <= reg_wdata;
         if (wr_misc) cfg_misc <= reg_wdata;
      end
   end

   // read data, one cycle after the strobe; unmapped reads zero
   wire [7:0] status = {chg_present, ldo_off, discharge_fet_drive, charge_fet_drive,
                        open_flt, scc_flt, scd_flt, ocd_flt};
   wire [7:0] rd_mux = (reg_addr == pcfp_pkg::ADDR_OCD)    ? cfg_ocd  :
                       (reg_addr == pcfp_pkg::ADDR_SCD)    ? cfg_scd  :
                       (reg_addr == pcfp_pkg::ADDR_SCC)    ? cfg_scc  :
                       (reg_addr == pcfp_pkg::ADDR_MISC)   ? cfg_misc :
                       (reg_addr == pcfp_pkg::ADDR_STATUS) ? status   : 8'h00;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // trip selects drive the comparator references
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         overcurrent_trip_sel <= 4'h0;
         dsg_short_trip_sel   <= 4'h0;
         chg_short_trip_sel   <= 4'h0;
      end else begin
         overcurrent_trip_sel <= cfg_ocd[pcfp_pkg::TRIP_LSB +: pcfp_pkg::SEL_W];
         dsg_short_trip_sel   <= cfg_scd[pcfp_pkg::TRIP_LSB +: pcfp_pkg::SEL_W];
         chg_short_trip_sel   <= cfg_scc[pcfp_pkg::TRIP_LSB +: pcfp_pkg::SEL_W];
      end
   end

   // fault latches: a new trip wins over a release in the same cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ocd_flt  <= 1'b0;
         scd_flt  <= 1'b0;
         scc_flt  <= 1'b0;
         open_flt <= 1'b0;
      end else begin
         ocd_flt  <= ocd_hit | (ocd_flt & ~dsg_release);
         scd_flt  <= scd_hit | (scd_flt & ~dsg_release);
         scc_flt  <= scc_hit | (scc_flt & ~scc_release);
         open_flt <= oc_set | open_flt;
      end
   end

   // charger presence seen since the discharge fault latched
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         chg_seen <= 1'b0;
      end else if (!dsg_flt) begin
         chg_seen <= 1'b0;
      end else if (chg_present) begin
         chg_seen <= 1'b1;
      end
   end

   // load presence window restarts each time the discharge FET turns off on a discharge fault
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         load_cnt <= 12'h000;
      end else if (!load_cmp_en) begin
         load_cnt <= 12'h000;
      end else if (!load_win_done && !load_sense_pin) begin
         load_cnt <= load_cnt + 12'h001;
      end else if (!load_win_done) begin
         load_cnt <= 12'h000;
      end
   end

   // outputs: FETs, regulator, load comparator enable
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         charge_fet_drive    <= 1'b0;
         discharge_fet_drive <= 1'b0;
         ldo_off             <= 1'b0;
         load_cmp_en         <= 1'b0;
      end else begin
         charge_fet_drive    <= ~any_flt;
         discharge_fet_drive <= ~any_flt;
         ldo_off             <= open_flt & ~chg_present;
         load_cmp_en         <= ~discharge_fet_drive & dsg_flt;
      end
   end

   // open-cell scan: wait an interval, probe one cell, evaluate
   always_comb begin
      next_oc_state = oc_state;
      unique case (oc_state)
         pcfp_pkg::PCFP_OC_WAIT: begin
            if (period_tick) next_oc_state = pcfp_pkg::PCFP_OC_PROBE;
         end
         pcfp_pkg::PCFP_OC_PROBE: begin
            if (probe_done) next_oc_state = pcfp_pkg::PCFP_OC_EVAL;
         end
         pcfp_pkg::PCFP_OC_EVAL: begin
            next_oc_state = pcfp_pkg::PCFP_OC_WAIT;
         end
         default: begin
            next_oc_state = pcfp_pkg::PCFP_OC_WAIT;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         oc_state <= pcfp_pkg::PCFP_OC_WAIT;
      end else begin
         oc_state <= next_oc_state;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         period_cnt <= 32'h00000000;
      end else if (oc_state != pcfp_pkg::PCFP_OC_WAIT || period_tick) begin
         period_cnt <= 32'h00000000;
      end else begin
         period_cnt <= period_cnt + 32'h00000001;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         probe_cnt <= 5'h00;
      end else if (oc_state == pcfp_pkg::PCFP_OC_PROBE) begin
         probe_cnt <= probe_cnt + 5'h01;
      end else begin
         probe_cnt <= 5'h00;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         probe_en <= 1'b0;
      end else begin
         // load stays applied through the evaluation cycle so the reading sees it
         probe_en <= (next_oc_state == pcfp_pkg::PCFP_OC_PROBE) ||
                     (next_oc_state == pcfp_pkg::PCFP_OC_EVAL);
      end
   end

   // cells taken in turn; each keeps whether its last check missed
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         probe_cell <= 4'h0;
         miss       <= 10'h000;
      end else if (oc_eval) begin
         miss[probe_cell] <= cell_collapse;
         probe_cell       <= last_cell ? 4'h0 : probe_cell + 4'h1;
      end
   end

   // checks
   property p_fet_off;
      @(posedge core_clk) disable iff (!arst_n)
      any_flt |=> (!charge_fet_drive && !discharge_fet_drive);
   endproperty
   a_fet_off: assert property (p_fet_off) else $error("fet on with fault");

   property p_ocd_trip;
      @(posedge core_clk) disable iff (!arst_n)
      ocd_hit |=> ##1 (!discharge_fet_drive && !charge_fet_drive);
   endproperty
   a_ocd_trip: assert property (p_ocd_trip) else $error("ocd did not open fets");

   property p_scc_hold;
      @(posedge core_clk) disable iff (!arst_n)
      (scc_flt && chg_present) |=> scc_flt;
   endproperty
   a_scc_hold: assert property (p_scc_hold) else $error("scc released early");

   property p_rec_mode0;
      @(posedge core_clk) disable iff (!arst_n)
      (dsg_release && !ocd_hit && !scd_hit) |=> !dsg_flt;
   endproperty
   a_rec_mode0: assert property (p_rec_mode0) else $error("dsg fault not released");

   property p_rec_mode1;
      @(posedge core_clk) disable iff (!arst_n)
      (dsg_flt && recovery_mode_bit && !chg_seen) |=> dsg_flt;
   endproperty
   a_rec_mode1: assert property (p_rec_mode1) else $error("released without charger");

   property p_ldo_off;
      @(posedge core_clk) disable iff (!arst_n)
      (open_flt && !chg_present) |=> ldo_off;
   endproperty
   a_ldo_off: assert property (p_ldo_off) else $error("regulator not shut down");

   property p_ldo_chg;
      @(posedge core_clk) disable iff (!arst_n)
      chg_present |=> !ldo_off;
   endproperty
   a_ldo_chg: assert property (p_ldo_chg) else $error("regulator off with charger");

   property p_load_en;
      @(posedge core_clk) disable iff (!arst_n)
      discharge_fet_drive |=> !load_cmp_en;
   endproperty
   a_load_en: assert property (p_load_en) else $error("load sensed with fet on");

   property p_two_miss;
      @(posedge core_clk) disable iff (!arst_n)
      // two edges back the index still names the evaluated cell
      $rose(open_flt) |-> $past(miss[probe_cell], 2);
   endproperty
   a_two_miss: assert property (p_two_miss) else $error("open cell on one miss");

   property p_open_hold;
      @(posedge core_clk) disable iff (!arst_n)
      open_flt |=> (open_flt && !discharge_fet_drive);
   endproperty
   a_open_hold: assert property (p_open_hold) else $error("open cell fault lost");
endmodule

// ---- pkg/pcfp_pkg.sv ----
package pcfp_pkg;
   // core clock
   localparam int CLK_MHZ = 50;

   // register indices on the plain register port
   localparam logic [2:0] ADDR_OCD    = 3'h0;
   localparam logic [2:0] ADDR_SCD    = 3'h1;
   localparam logic [2:0] ADDR_SCC    = 3'h2;
   localparam logic [2:0] ADDR_MISC   = 3'h3;
   localparam logic [2:0] ADDR_STATUS = 3'h4;

   // trip/delay config fields: trip select low nibble, delay select high nibble
   localparam int TRIP_LSB  = 0;
   localparam int DELAY_LSB = 4;
   localparam int SEL_W     = 4;

   // misc config fields
   localparam int MODE_BIT  = 0;
   localparam int CELLS_LSB = 4;

   // status fields
   localparam int ST_OCD  = 0;
   localparam int ST_SCD  = 1;
   localparam int ST_SCC  = 2;
   localparam int ST_OPEN = 3;
   localparam int ST_CFET = 4;
   localparam int ST_DFET = 5;
   localparam int ST_LDO  = 6;
   localparam int ST_CHGR = 7;

   // reset values
   localparam logic [7:0] RST_OCD  = 8'h00;
   localparam logic [7:0] RST_SCD  = 8'h00;
   localparam logic [7:0] RST_SCC  = 8'h00;
   localparam logic [7:0] RST_MISC = 8'ha0;

   // cell range
   localparam int          MAX_CELLS = 10;
   localparam logic [3:0]  MIN_CELLS = 4'h4;

   // timing: overcurrent delay step 20 ms, minimum one step
   localparam int OCD_STEP_MS = 20;
   // short-circuit delay: 60 us steps, 120 us minimum (two steps)
   localparam int SC_STEP_US  = 60;
   localparam int SC_STEP_CYC = SC_STEP_US * CLK_MHZ;
   localparam int SC_MIN_STEPS = 2;
   // load must show within 75 us (longest time, rounded down)
   localparam int LOAD_WIN_US  = 75;
   localparam int LOAD_WIN_CYC = LOAD_WIN_US * CLK_MHZ;
   // open-cell check interval, plain default
   localparam int OC_PERIOD_MS = 500;
   // probe load applied for this many cycles before the reading
   localparam int PROBE_CYC = 16;

   typedef enum logic [1:0] {
      PCFP_OC_WAIT  = 2'b00,
      PCFP_OC_PROBE = 2'b01,
      PCFP_OC_EVAL  = 2'b10
   } pcfp_oc_state_t;
endpackage

// ---- verilog/pcfp_qual.sv ----
`timescale 1ns/1ns
// persistence filter: hit after cond holds continuously for limit cycles
module pcfp_qual (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // condition and blanking length
   input  wire logic        cond,
   input  wire logic [23:0] limit,
   // qualified fault
   output logic             hit
);
   logic [23:0] count;
   wire         at_limit = (count >= limit);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= 24'h000000;
      end else if (!cond) begin
         count <= 24'h000000;
      end else if (!at_limit) begin
         count <= count + 24'h000001;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hit <= 1'b0;
      end else begin
         hit <= cond & at_limit;
      end
   end
endmodule

// ---- sim/pcfp_far_model.sv ----
`timescale 1ns/1ns
// far side: sense comparators, pack load, charger and cell stack
module pcfp_far_model (
   // scenario controls from the bench
   input  wire logic [4:0] dsg_amp,
   input  wire logic [4:0] chg_amp,
   input  wire logic       load_on,
   input  wire logic       chgr_on,
   input  wire logic       open_on,
   input  wire logic [3:0] open_cell,
   // block outputs seen by the far side
   input  wire logic [3:0] overcurrent_trip_sel,
   input  wire logic [3:0] dsg_short_trip_sel,
   input  wire logic [3:0] chg_short_trip_sel,
   input  wire logic       charge_fet_drive,
   input  wire logic       discharge_fet_drive,
   input  wire logic       probe_en,
   input  wire logic [3:0] probe_cell,
   // comparator and pin levels
   output logic            ocd_cmp,
   output logic            scd_cmp,
   output logic            scc_cmp,
   output logic            load_sense_pin,
   output logic            charger_sense_pin,
   output logic            cell_collapse
);
   // current flows only through a closed FET, so an opened path stops the trip
   assign ocd_cmp = discharge_fet_drive & (dsg_amp > {1'b0, overcurrent_trip_sel});
   assign scd_cmp = discharge_fet_drive & (dsg_amp > {1'b0, dsg_short_trip_sel});
   assign scc_cmp = charge_fet_drive & (chg_amp > {1'b0, chg_short_trip_sel});
   // an attached load pulls the pin up once the FET opens; the pulldown wins otherwise
   assign load_sense_pin = load_on & ~discharge_fet_drive;
   assign charger_sense_pin = chgr_on;
   assign cell_collapse = probe_en & open_on & (probe_cell == open_cell);
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ns
module tb;
   localparam int OCD_STEP = 50;
   localparam int OC_PER   = 40;
   localparam int ROUND    = OC_PER + pcfp_pkg::PROBE_CYC + 1;
   logic       core_clk, arst_n, reg_wr, reg_rd;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic       ocd_cmp, scd_cmp, scc_cmp, load_sense_pin, charger_sense_pin, cell_collapse;
   logic [3:0] overcurrent_trip_sel, dsg_short_trip_sel, chg_short_trip_sel, probe_cell;
   logic       charge_fet_drive, discharge_fet_drive, ldo_off, load_cmp_en, probe_en;
   logic [4:0] dsg_amp, chg_amp;
   logic       load_on, chgr_on, open_on;
   logic [3:0] open_cell, dl, tr;
   logic [31:0] seed;
   int         fails, n_checks, lim, i;
   logic [7:0] rst_tab [6];

   pcfp_top #(.OCD_STEP_CYC(OCD_STEP), .OC_PERIOD_CYC(OC_PER)) DUT (.*);
   pcfp_far_model far (.*);

   always #10 core_clk = ~core_clk;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int sc_limit(logic [3:0] s);
      return (s + pcfp_pkg::SC_MIN_STEPS) * pcfp_pkg::SC_STEP_CYC;
   endfunction

   task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
      n_checks++;
      if (got !== exp) begin
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
         fails++;
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(logic [2:0] a, logic [7:0] v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd_reg(logic [2:0] a, output logic [7:0] v);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      v = reg_rdata;
      @(posedge core_clk);
   endtask
   task automatic wait_fets(logic e, int max, string what);
      for (int k = 0; k < max; k++) begin
         @(negedge core_clk);
         if ({charge_fet_drive, discharge_fet_drive} === {e, e}) break;
      end
      chk({6'h0, charge_fet_drive, discharge_fet_drive}, {6'h0, e, e}, what);
      @(posedge core_clk);
   endtask
   task automatic hold_fets(logic e, int n, string what);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         @(negedge core_clk);
         if ({charge_fet_drive, discharge_fet_drive} !== {e, e}) bad = 1'b1;
      end
      chk({7'h0, bad}, 8'h00, what);
      @(posedge core_clk);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge core_clk);
      fails++;
      complete_run();
   end

   initial begin
      core_clk = 0; arst_n = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
      dsg_amp = 0; chg_amp = 0; load_on = 0; chgr_on = 0; open_on = 0; open_cell = 0;
      fails = 0; n_checks = 0; seed = 32'h852c3166;
      rst_tab = '{pcfp_pkg::RST_OCD, pcfp_pkg::RST_SCD, pcfp_pkg::RST_SCC,
                  pcfp_pkg::RST_MISC, 8'h30, 8'h00};
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      cyc(3);
      // reset values, read-only status, unmapped place 5
      wr(3'h4, 8'hff);
      wr(3'h5, 8'hff);
      for (i = 0; i < 6; i++) begin
         rd_reg(i[2:0], d);
         chk(d, rst_tab[i], "reset value");
      end
      // random config readback and trip selects
      for (i = 0; i < 3; i++) begin
         wr(i[2:0], xs());
         rd_reg(i[2:0], d);
         chk(d, seed[7:0], "config readback");
         chk({4'h0, i == 0 ? overcurrent_trip_sel : i == 1 ? dsg_short_trip_sel
              : chg_short_trip_sel}, {4'h0, seed[3:0]}, "trip select");
      end
      $display("test registers done");
      // discharge overcurrent, recovery on load removal
      wr(3'h3, 8'h40);
      dl = xs() % 4;
      tr = xs() % 15;
      lim = (dl + 1) * OCD_STEP;
      wr(3'h0, {dl, tr});
      wr(3'h1, 8'h0f);
      wr(3'h2, 8'h0f);
      load_on <= 1'b1;
      dsg_amp <= tr + 5'h1;
      cyc(lim - 5);
      dsg_amp <= 5'h0;
      hold_fets(1'b1, 20, "short overload ignored");
      dsg_amp <= tr + 5'h1;
      hold_fets(1'b1, lim, "overload before delay");
      wait_fets(1'b0, 10, "overload trip");
      dsg_amp <= 5'h0;
      rd_reg(3'h4, d);
      chk(d, 8'h01, "overload status");
      chk({7'h0, load_cmp_en}, 8'h01, "load comparator on");
      hold_fets(1'b0, 4000, "load still attached");
      load_on <= 1'b0;
      hold_fets(1'b0, pcfp_pkg::LOAD_WIN_CYC - 50, "load window");
      wait_fets(1'b1, 80, "recovery mode 0");
      $display("test overcurrent done");
      // discharge short, recovery needs charger too
      wr(3'h3, 8'h41);
      dl = xs() % 2;
      tr = xs() % 15;
      lim = sc_limit(dl);
      wr(3'h0, 8'h0f);
      wr(3'h1, {dl, tr});
      dsg_amp <= tr + 5'h1;
      hold_fets(1'b1, lim, "short before delay");
      wait_fets(1'b0, 10, "discharge short trip");
      dsg_amp <= 5'h0;
      rd_reg(3'h4, d);
      chk(d, 8'h02, "short status");
      hold_fets(1'b0, 5000, "no charger yet");
      chgr_on <= 1'b1;
      wait_fets(1'b1, 10, "recovery mode 1");
      chgr_on <= 1'b0;
      $display("test discharge short done");
      // charge short latched until charger removal
      wr(3'h3, 8'h40);
      dl = xs() % 2;
      tr = xs() % 15;
      lim = sc_limit(dl);
      wr(3'h2, {dl, tr});
      chgr_on <= 1'b1;
      chg_amp <= tr + 5'h1;
      hold_fets(1'b1, lim, "charge short before delay");
      wait_fets(1'b0, 10, "charge short trip");
      chg_amp <= 5'h0;
      rd_reg(3'h4, d);
      chk(d, 8'h84, "charge short status");
      hold_fets(1'b0, 1000, "charger still present");
      chgr_on <= 1'b0;
      wait_fets(1'b1, 10, "charger removed");
      $display("test charge short done");
      // open cell: one miss ignored, two confirm
      open_cell <= 4'h2;
      open_on <= 1'b1;
      for (i = 0; i < 6 * ROUND && !(probe_en && probe_cell == 4'h2); i++) @(negedge core_clk);
      for (i = 0; i < 40 && probe_en; i++) @(negedge core_clk);
      @(posedge core_clk);
      open_on <= 1'b0;
      hold_fets(1'b1, 2 * 4 * ROUND, "single miss");
      open_on <= 1'b1;
      wait_fets(1'b0, 2 * 4 * ROUND + 10, "open cell trip");
      open_on <= 1'b0;
      hold_fets(1'b0, 2 * ROUND, "open cell stays");
      rd_reg(3'h4, d);
      chk(d, 8'h48, "open cell status");
      chgr_on <= 1'b1;
      cyc(3);
      chk({7'h0, ldo_off}, 8'h00, "charger keeps regulator");
      chgr_on <= 1'b0;
      cyc(3);
      chk({7'h0, ldo_off}, 8'h01, "charger gone");
      // wake: fault cleared and qualified again from scratch
      arst_n <= 1'b0;
      cyc(2);
      arst_n <= 1'b1;
      open_on <= 1'b1;
      wait_fets(1'b1, 3, "wake clears fault");
      hold_fets(1'b1, 4 * ROUND, "requalify");
      wait_fets(1'b0, 2 * 10 * ROUND, "open cell again");
      $display("test open cell done");
      complete_run();
   end
endmodule
